/* File: src/torque_select_pkg.sv */
// Constants and types for the torque command select block.
// Assumes a single 50 MHz clock and a plain 16-bit register port.
`default_nettype none

package torque_select_pkg;

    // Register byte offsets on the plain register port
    localparam logic [15:0] ADDR_MODE = 16'h0000;
    localparam logic [15:0] ADDR_PRESET_ONE = 16'h0006;
    localparam logic [15:0] ADDR_PRESET_TWO = 16'h0008;
    localparam logic [15:0] ADDR_PRESET_THREE = 16'h000a;
    localparam logic [15:0] ADDR_STATUS = 16'h0010;
    localparam logic [15:0] ADDR_TORQUE_OUT = 16'h0012;
    localparam logic [15:0] ADDR_SPEED_ONE = 16'h001c;
    localparam logic [15:0] ADDR_SPEED_TWO = 16'h001e;
    localparam logic [15:0] ADDR_SPEED_THREE = 16'h0020;
    localparam logic [15:0] ADDR_SCALE = 16'h0024;
    localparam logic [15:0] ADDR_SMOOTH = 16'h0102;

    // Values after reset
    localparam logic [15:0] RST_SCALE = 16'h0064;
    localparam logic [15:0] RST_SMOOTH = 16'h0000;
    localparam logic [15:0] RST_PRESET = 16'h0000;
    localparam logic [3:0] RST_MODE = 4'h0;

    // Operating mode codes
    localparam logic [3:0] MODE_POSITION = 4'h0;
    localparam logic [3:0] MODE_TORQUE_ZERO = 4'h1;
    localparam logic [3:0] MODE_SPEED = 4'h2;
    localparam logic [3:0] MODE_TORQUE = 4'h3;
    localparam logic [3:0] MODE_SPEED_ZERO = 4'h4;
    localparam logic [3:0] MODE_POS_SPEED = 4'h5;
    localparam logic [3:0] MODE_POS_TORQUE = 4'h6;
    localparam logic [3:0] MODE_SPEED_TORQUE = 4'h7;

    // Ranges; torque values are in 0.1 percent of rated torque
    localparam int SCALE_MAX = 300;
    localparam int SMOOTH_MAX_MS = 1000;
    localparam int PRESET_LIMIT = 3000;
    localparam int ANALOG_FULL_MV = 10000;
    localparam int SCALE_DIVISOR = 1000;
    localparam int FILTER_FRAC_BITS = 8;

    // Filter update period
    localparam int CLK_PERIOD_NS = 20;
    localparam int FILTER_STEP_NS = 1000000;
    localparam int FILTER_TICK_CYCLES = FILTER_STEP_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        LOOP_POSITION,
        LOOP_SPEED,
        LOOP_TORQUE
    } loop_type;

endpackage

`default_nettype wire

/* File: src/torque_command_select.sv */
// Torque command select: presets, scaled analog reference (smoothed for the demand, not the limit),
// torque demand or limit, and mixed operating mode switching.
// Assumes select inputs synchronous to sys_clk; analog input in signed mV.
//
// Added by the designer: the address-and-strobe port.
`default_nettype none

module torque_command_select #(
    parameter int FILTER_TICK = torque_select_pkg::FILTER_TICK_CYCLES
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic servo_on,
    input wire logic torque_select_bit0,
    input wire logic torque_select_bit1,
    input wire logic speed_select_bit0,
    input wire logic speed_select_bit1,
    input wire logic mode_switch_input,
    input wire logic signed [15:0] analog_torque_mv,
    input wire logic signed [15:0] analog_speed_ref,
    output logic signed [15:0] torque_demand,
    output logic signed [15:0] torque_limit,
    output logic signed [15:0] speed_command,
    output logic position_from_pulses,
    output torque_select_pkg::loop_type active_loop
);
    import torque_select_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic signed [15:0] sat_signed(input logic signed [31:0] v,
                                                      input int lim);
        if (v > lim) begin
            sat_signed = 16'(lim);
        end else if (v < -lim) begin
            sat_signed = 16'(-lim);
        end else begin
            sat_signed = v[15:0];
        end
    endfunction

    function automatic logic [15:0] sat_unsigned(input logic [15:0] v, input int lim);
        sat_unsigned = (32'(v) > lim) ? 16'(lim) : v;
    endfunction

    function automatic logic signed [15:0] pick3(input logic [1:0] sel,
                                                 input logic signed [15:0] a,
                                                 input logic signed [15:0] b,
                                                 input logic signed [15:0] c);
        pick3 = (sel == 2'b01) ? a : ((sel == 2'b10) ? b : c);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [3:0] mode_ff;
    logic [15:0] scale_ff;
    logic [15:0] smooth_ff;
    logic signed [15:0] preset_one_ff, preset_two_ff, preset_three_ff;
    logic signed [15:0] speed_one_ff, speed_two_ff, speed_three_ff;
    logic [15:0] rdata_ff;
    logic signed [31:0] filt_acc_ff;
    logic [31:0] tick_cnt_ff;
    logic signed [15:0] demand_ff, limit_ff, speed_ff;
    logic pulses_ff;
    loop_type loop_ff;

    logic wr_mode, wr_scale, wr_smooth, wr_p1, wr_p2, wr_p3, wr_s1, wr_s2, wr_s3;
    assign wr_mode = reg_wr && (reg_addr == ADDR_MODE);
    assign wr_scale = reg_wr && (reg_addr == ADDR_SCALE);
    assign wr_smooth = reg_wr && (reg_addr == ADDR_SMOOTH);
    assign wr_p1 = reg_wr && (reg_addr == ADDR_PRESET_ONE);
    assign wr_p2 = reg_wr && (reg_addr == ADDR_PRESET_TWO);
    assign wr_p3 = reg_wr && (reg_addr == ADDR_PRESET_THREE);
    assign wr_s1 = reg_wr && (reg_addr == ADDR_SPEED_ONE);
    assign wr_s2 = reg_wr && (reg_addr == ADDR_SPEED_TWO);
    assign wr_s3 = reg_wr && (reg_addr == ADDR_SPEED_THREE);

    // mode code check
    // Codes outside the table, including any zero-speed/zero-torque pair, are ignored
    logic mode_ok;
    assign mode_ok = (reg_wdata[15:4] == 12'h000) && (reg_wdata[3:0] <= MODE_SPEED_TORQUE);

    logic signed [15:0] wpreset;
    assign wpreset = sat_signed(32'(signed'(reg_wdata)), PRESET_LIMIT);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mode_ff <= RST_MODE;
            scale_ff <= RST_SCALE;
            smooth_ff <= RST_SMOOTH;
            preset_one_ff <= RST_PRESET;
            preset_two_ff <= RST_PRESET;
            preset_three_ff <= RST_PRESET;
            speed_one_ff <= RST_PRESET;
            speed_two_ff <= RST_PRESET;
            speed_three_ff <= RST_PRESET;
        end else begin
            if (wr_mode && mode_ok) mode_ff <= reg_wdata[3:0];
            if (wr_scale) scale_ff <= sat_unsigned(reg_wdata, SCALE_MAX);
            if (wr_smooth) smooth_ff <= sat_unsigned(reg_wdata, SMOOTH_MAX_MS);
            if (wr_p1) preset_one_ff <= wpreset;
            if (wr_p2) preset_two_ff <= wpreset;
            if (wr_p3) preset_three_ff <= wpreset;
            if (wr_s1) speed_one_ff <= reg_wdata;
            if (wr_s2) speed_two_ff <= reg_wdata;
            if (wr_s3) speed_three_ff <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode decode

    loop_type nxt_loop;
    always_comb begin
        case (mode_ff)
            MODE_SPEED, MODE_SPEED_ZERO: nxt_loop = LOOP_SPEED;
            MODE_TORQUE, MODE_TORQUE_ZERO: nxt_loop = LOOP_TORQUE;
            MODE_POS_SPEED: nxt_loop = mode_switch_input ? LOOP_SPEED : LOOP_POSITION;
            MODE_POS_TORQUE: nxt_loop = mode_switch_input ? LOOP_TORQUE : LOOP_POSITION;
            MODE_SPEED_TORQUE: nxt_loop = mode_switch_input ? LOOP_TORQUE : LOOP_SPEED;
            default: nxt_loop = LOOP_POSITION;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Analog scaling and smoothing

    logic [1:0] tsel, ssel;
    assign tsel = {torque_select_bit1, torque_select_bit0};
    assign ssel = {speed_select_bit1, speed_select_bit0};

    // out-of-range input is clipped rather than trusted
    logic signed [15:0] mv_clip;
    assign mv_clip = sat_signed(32'(analog_torque_mv), ANALOG_FULL_MV);

    // volts times scale, in 0.1 percent
    logic signed [31:0] scaled_prod;
    logic signed [15:0] analog_scaled;
    assign scaled_prod = 32'(mv_clip) * $signed({16'h0000, scale_ff});
    assign analog_scaled = sat_signed(scaled_prod / SCALE_DIVISOR, PRESET_LIMIT);

    logic filt_tick;
    assign filt_tick = (tick_cnt_ff == 32'(FILTER_TICK - 1));

    logic signed [31:0] target_fx, nxt_filt_acc, filt_step;
    assign target_fx = 32'(analog_scaled) <<< FILTER_FRAC_BITS;
    assign filt_step = (target_fx - filt_acc_ff) / $signed({16'h0000, smooth_ff});
    // first-order step once per millisecond; zero bypasses
    // Snap once the step truncates to zero, else the output stalls short of the target
    assign nxt_filt_acc = (smooth_ff == 16'h0000) ? target_fx :
        (!filt_tick ? filt_acc_ff :
         ((filt_step == 32'sh00000000) ? target_fx : filt_acc_ff + filt_step));

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tick_cnt_ff <= 32'h00000000;
            filt_acc_ff <= 32'h00000000;
        end else begin
            tick_cnt_ff <= filt_tick ? 32'h00000000 : tick_cnt_ff + 32'h00000001;
            filt_acc_ff <= nxt_filt_acc;
        end
    end

    logic signed [15:0] analog_filtered;
    assign analog_filtered = (smooth_ff == 16'h0000) ? analog_scaled :
        16'(filt_acc_ff >>> FILTER_FRAC_BITS);

    ////////////////////////////////////////////////////////////////////////
    // Command selection

    logic signed [15:0] torque_preset, torque_sel, speed_sel;
    logic signed [15:0] nxt_demand, nxt_limit, nxt_speed;
    assign torque_preset = pick3(tsel, preset_one_ff, preset_two_ff, preset_three_ff);
    // zero or analog at code 00
    assign torque_sel = (tsel != 2'b00) ? torque_preset :
        ((mode_ff == MODE_TORQUE_ZERO) ? 16'sh0000 : analog_filtered);
    assign speed_sel = (ssel == 2'b00) ? analog_speed_ref :
        pick3(ssel, speed_one_ff, speed_two_ff, speed_three_ff);

    // commands only while the servo is on
    assign nxt_demand = (servo_on && nxt_loop == LOOP_TORQUE) ? torque_sel : 16'sh0000;
    // analog limit; selected command limits in speed loop
    assign nxt_limit = (!servo_on || nxt_loop == LOOP_TORQUE) ? 16'sh0000 :
        ((nxt_loop == LOOP_SPEED && tsel != 2'b00) ? torque_preset : analog_scaled);
    assign nxt_speed = (servo_on && nxt_loop == LOOP_SPEED) ? speed_sel : 16'sh0000;

    // outputs follow inputs at the next edge and hold
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            demand_ff <= 16'sh0000;
            limit_ff <= 16'sh0000;
            speed_ff <= 16'sh0000;
            pulses_ff <= 1'b0;
            loop_ff <= LOOP_POSITION;
        end else begin
            demand_ff <= nxt_demand;
            limit_ff <= nxt_limit;
            speed_ff <= nxt_speed;
            pulses_ff <= servo_on && (nxt_loop == LOOP_POSITION);
            loop_ff <= nxt_loop;
        end
    end

    assign torque_demand = demand_ff;
    assign torque_limit = limit_ff;
    assign speed_command = speed_ff;
    assign position_from_pulses = pulses_ff;
    assign active_loop = loop_ff;

    ////////////////////////////////////////////////////////////////////////
    // Register read port

    logic [15:0] nxt_rdata;
    always_comb begin
        if (!reg_rd) begin
            nxt_rdata = 16'h0000;
        end else if (reg_addr == ADDR_MODE) begin
            nxt_rdata = {12'h000, mode_ff};
        end else if (reg_addr == ADDR_SCALE) begin
            nxt_rdata = scale_ff;
        end else if (reg_addr == ADDR_SMOOTH) begin
            nxt_rdata = smooth_ff;
        end else if (reg_addr == ADDR_PRESET_ONE) begin
            nxt_rdata = preset_one_ff;
        end else if (reg_addr == ADDR_PRESET_TWO) begin
            nxt_rdata = preset_two_ff;
        end else if (reg_addr == ADDR_PRESET_THREE) begin
            nxt_rdata = preset_three_ff;
        end else if (reg_addr == ADDR_SPEED_ONE) begin
            nxt_rdata = speed_one_ff;
        end else if (reg_addr == ADDR_SPEED_TWO) begin
            nxt_rdata = speed_two_ff;
        end else if (reg_addr == ADDR_SPEED_THREE) begin
            nxt_rdata = speed_three_ff;
        end else if (reg_addr == ADDR_STATUS) begin
            nxt_rdata = {11'h000, pulses_ff, tsel, loop_ff};
        end else if (reg_addr == ADDR_TORQUE_OUT) begin
            nxt_rdata = demand_ff;
        end else begin
            nxt_rdata = 16'h0000;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdata_ff <= 16'h0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end
    assign reg_rdata = rdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_scale_write_clamp: assert property (
        wr_scale |=> scale_ff == ((32'($past(reg_wdata)) > SCALE_MAX) ? 16'(SCALE_MAX)
                                  : $past(reg_wdata)))
        else $error("scale write not clamped to range");

    a_preset_demand_pick: assert property (
        servo_on && nxt_loop == LOOP_TORQUE && tsel == 2'b10 && !wr_p2
        |=> torque_demand == preset_two_ff)
        else $error("preset two not applied as demand");

    a_zero_mode_zero: assert property (
        servo_on && mode_ff == MODE_TORQUE_ZERO && tsel == 2'b00 |=> torque_demand == 0)
        else $error("zero torque mode gave nonzero demand");

    a_preset_range_hold: assert property (
        torque_demand <= PRESET_LIMIT && torque_demand >= -PRESET_LIMIT)
        else $error("torque demand out of range");

    a_analog_limit_path: assert property (
        servo_on && mode_ff == MODE_POSITION |=> torque_limit == $past(analog_scaled))
        else $error("analog torque limit not applied");

    a_unsmoothed_pass: assert property (
        servo_on && mode_ff == MODE_TORQUE && smooth_ff == 0 && tsel == 2'b00
        |=> torque_demand == $past(analog_scaled))
        else $error("unsmoothed analog command not passed");

    a_mixed_switch_now: assert property (
        mode_ff == MODE_SPEED_TORQUE && !wr_mode && $rose(mode_switch_input)
        |=> active_loop == LOOP_TORQUE)
        else $error("speed/torque switch late");

    a_servo_off_quiet: assert property (
        !servo_on |=> torque_demand == 0 && speed_command == 0 && !position_from_pulses)
        else $error("command present while servo off");

    a_read_one_cycle: assert property (
        reg_rd && reg_addr == ADDR_SCALE && !wr_scale |=> reg_rdata == scale_ff)
        else $error("scale readback wrong");

    c_preset_three: cover property (servo_on && active_loop == LOOP_TORQUE && tsel == 2'b11);
    c_speed_torque_flip: cover property (mode_ff == MODE_SPEED_TORQUE
        && active_loop == LOOP_SPEED ##1 active_loop == LOOP_TORQUE);
    c_filter_step: cover property (filt_tick && smooth_ff != 0);

endmodule

`default_nettype wire

/* File: sim/host_ctrl_model.sv */
// Model of the host motion controller: select contacts and analog references.
// Assumes the bench changes requests right after a rising edge of sys_clk.
`default_nettype none

module host_ctrl_model (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [5:0] req_bits,
    input wire logic signed [15:0] req_mv,
    input wire logic signed [15:0] req_spd,
    output logic [5:0] pins,
    output logic signed [15:0] analog_mv,
    output logic signed [15:0] speed_ref
);
    timeunit 1ns;
    timeprecision 1ns;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pins <= '0;
            analog_mv <= '0;
            speed_ref <= '0;
        end else begin
            pins <= req_bits;
            speed_ref <= req_spd;
            analog_mv <= (req_mv > 16'sd10000) ? 16'sd10000 :
                         (req_mv < -16'sd10000) ? -16'sd10000 : req_mv;
        end
    end
endmodule

`default_nettype wire

/* File: sim/torque_command_select_tb_top.sv */
// Self-checking bench for the torque command select block.
// Assumes the host model drives the pins; the bench owns the register port.
`default_nettype none

module torque_command_select_tb_top;
    import torque_select_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [3:0] care;
        logic [15:0] dem;
        logic [15:0] lim;
        logic [15:0] spd;
        logic [2:0] lp;
    } exp_type;

    logic sys_clk, sys_rst, reg_wr, reg_rd, probe, position_from_pulses;
    logic rd_d = 1'b0;
    logic [15:0] reg_addr, reg_wdata, reg_rdata;
    logic [5:0] req_bits, pins;
    logic signed [15:0] req_mv, req_spd, analog_mv, spd_ref;
    logic signed [15:0] torque_demand, torque_limit, speed_command;
    loop_type active_loop, lpv;
    logic [15:0] rd_q[$];
    exp_type out_q[$];
    exp_type e;
    int bad_count, checked, mv;
    int tq_preset[4] = '{0, 1234, -3000, 3000};
    int scales[3] = '{300, 100, 0};
    logic [31:0] seed;

    host_ctrl_model host (.sys_clk, .sys_rst, .req_bits, .req_mv, .req_spd, .pins,
        .analog_mv, .speed_ref(spd_ref));

    torque_command_select #(.FILTER_TICK(10)) dut (.sys_clk, .sys_rst, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .servo_on(pins[5]),
        .torque_select_bit0(pins[0]), .torque_select_bit1(pins[1]),
        .speed_select_bit0(pins[2]), .speed_select_bit1(pins[3]),
        .mode_switch_input(pins[4]), .analog_torque_mv(analog_mv),
        .analog_speed_ref(spd_ref), .torque_demand, .torque_limit, .speed_command,
        .position_from_pulses, .active_loop);

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    function automatic int scaled(input int v, input int s);
        return v * s / 1000;
    endfunction

    task automatic print_verdict();
        if (bad_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Strobes drop for one cycle so no signal is set twice in one step
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] d);
        reg_rd <= 1'b1;
        reg_addr <= a;
        rd_q.push_back(d);
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic drive(input logic [5:0] b, input int v);
        req_bits <= b;
        req_mv <= 16'(v);
    endtask

    // Host model adds one cycle, the block one more
    task automatic chk_out(input int dem, input int lim, input int spd,
                           input loop_type lp, input logic [3:0] care);
        repeat (3) @(posedge sys_clk);
        probe <= 1'b1;
        out_q.push_back('{care, 16'(dem), 16'(lim), 16'(spd), {lp == LOOP_POSITION, lp}});
        @(posedge sys_clk);
        probe <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk) begin
        rd_d <= reg_rd;
        if (rd_d) cmp("reg_rdata", rd_q.pop_front(), reg_rdata);
        if (probe) begin
            e = out_q.pop_front();
            if (e.care[0]) cmp("torque_demand", e.dem, torque_demand);
            if (e.care[1]) cmp("torque_limit", e.lim, torque_limit);
            if (e.care[2]) cmp("speed_command", e.spd, speed_command);
            if (e.care[3]) cmp("loop_state", {13'h0, e.lp},
                               {13'h0, position_from_pulses, active_loop});
        end
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        print_verdict();
    end

    initial begin
        sys_rst = 1'b1;
        {reg_wr, reg_rd, probe} = '0;
        reg_addr = '0;
        reg_wdata = '0;
        req_bits = '0;
        req_mv = '0;
        req_spd = 16'sd777;
        bad_count = 0;
        checked = 0;
        seed = 32'd36369;
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        rd(ADDR_SCALE, 16'h0064);
        rd(ADDR_SMOOTH, 16'h0000);
        rd(ADDR_MODE, 16'h0000);
        rd(16'h0050, 16'h0000);
        wr(ADDR_SCALE, 16'h01f4);
        rd(ADDR_SCALE, 16'h012c);
        wr(ADDR_SMOOTH, 16'h07d0);
        rd(ADDR_SMOOTH, 16'h03e8);
        wr(ADDR_SMOOTH, 16'h0000);
        wr(ADDR_SCALE, 16'h0064);
        wr(ADDR_PRESET_ONE, 16'h04d2);
        wr(ADDR_PRESET_TWO, 16'hf254);
        wr(ADDR_PRESET_THREE, 16'h0dac);
        wr(ADDR_SPEED_TWO, 16'h0222);
        rd(ADDR_PRESET_ONE, 16'h04d2);
        rd(ADDR_PRESET_TWO, 16'hf448);
        rd(ADDR_PRESET_THREE, 16'h0bb8);
        wr(ADDR_MODE, {12'h0, MODE_TORQUE});
        for (int c = 0; c < 4; c++) begin
            drive(6'h20 | 6'(c), 5000);
            chk_out(c == 0 ? 500 : tq_preset[c], 0, 0, LOOP_TORQUE, 4'hb);
        end
        wr(ADDR_MODE, {12'h0, MODE_TORQUE_ZERO});
        drive(6'h20, -7000);
        chk_out(0, 0, 0, LOOP_TORQUE, 4'hb);
        wr(ADDR_MODE, {12'h0, MODE_TORQUE});
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            mv = i < 2 ? (i == 1 ? -10000 : 10000) : int'(seed % 20001) - 10000;
            wr(ADDR_SCALE, 16'(scales[i % 3]));
            drive(6'h20, mv);
            chk_out(scaled(mv, scales[i % 3]), 0, 0, LOOP_TORQUE, 4'h9);
        end
        // Smoothed step must settle exactly on the scaled target
        wr(ADDR_SCALE, 16'h0064);
        wr(ADDR_SMOOTH, 16'h0002);
        drive(6'h20, 5000);
        repeat (300) @(posedge sys_clk);
        chk_out(500, 0, 0, LOOP_TORQUE, 4'h9);
        wr(ADDR_SCALE, 16'h012c);
        wr(ADDR_MODE, {12'h0, MODE_SPEED});
        drive(6'h20, 5000);
        chk_out(0, 1500, 777, LOOP_SPEED, 4'he);
        drive(6'h22, 5000);
        chk_out(0, -3000, 777, LOOP_SPEED, 4'ha);
        wr(ADDR_MODE, {12'h0, MODE_POSITION});
        drive(6'h20, -4000);
        chk_out(0, -1200, 0, LOOP_POSITION, 4'ha);
        for (int m = 5; m <= 7; m++) begin
            for (int s = 0; s < 2; s++) begin
                wr(ADDR_MODE, 16'(m));
                drive(6'h29 | 6'(s << 4), 5000);
                lpv = (m == 7) ? (s == 1 ? LOOP_TORQUE : LOOP_SPEED) :
                      (s == 0 ? LOOP_POSITION : (m == 5 ? LOOP_SPEED : LOOP_TORQUE));
                chk_out(1234, 0, 16'h0222, lpv, lpv == LOOP_TORQUE ? 4'h9 :
                        (lpv == LOOP_SPEED ? 4'hc : 4'h8));
            end
        end
        wr(ADDR_MODE, 16'h0008);
        rd(ADDR_MODE, 16'h0007);
        drive(6'h0b, 5000);
        chk_out(0, 0, 0, LOOP_POSITION, 4'h7);
        print_verdict();
    end
endmodule

`default_nettype wire
